// *** logic/sdt_pkg.sv ***
// Constants, types and layout of the scannable dual byte transceiver
package sdt_pkg;

    localparam int GROUP_WIDTH  = 9;
    localparam int GROUP_COUNT  = 2;
    localparam int BSR_LENGTH   = 80;
    localparam int IR_WIDTH     = 8;

    // Boundary cell positions, group 1; group 2 control cells sit one stride lower, its data cells nine lower
    localparam int BSR_DIR      = 79;
    localparam int BSR_OEN      = 78;
    localparam int BSR_AOE      = 77;
    localparam int BSR_BOE      = 76;
    localparam int CTRL_STRIDE  = 4;
    localparam int BSR_A_IN     = 71;
    localparam int BSR_B_OUT    = 53;
    localparam int BSR_B_IN     = 35;
    localparam int BSR_A_OUT    = 17;

    localparam logic [7:0] OP_EXTEST  = 8'h00;
    localparam logic [7:0] OP_SAMPLE  = 8'h81;
    localparam logic [7:0] OP_CLAMP   = 8'h82;
    localparam logic [7:0] OP_HIGHZ   = 8'h03;
    localparam logic [7:0] OP_BYPASS  = 8'hff;
    // Arbitrary neutral capture value; only the low 01 is fixed
    localparam logic [7:0] IR_CAPTURE = 8'h55;

    localparam logic [BSR_LENGTH-1:0] BSR_RESET = 80'h0;

    typedef enum logic [15:0] {
        TAP_RESET      = 16'h0001,
        TAP_IDLE       = 16'h0002,
        TAP_SEL_DR     = 16'h0004,
        TAP_CAPTURE_DR = 16'h0008,
        TAP_SHIFT_DR   = 16'h0010,
        TAP_EXIT1_DR   = 16'h0020,
        TAP_PAUSE_DR   = 16'h0040,
        TAP_EXIT2_DR   = 16'h0080,
        TAP_UPDATE_DR  = 16'h0100,
        TAP_SEL_IR     = 16'h0200,
        TAP_CAPTURE_IR = 16'h0400,
        TAP_SHIFT_IR   = 16'h0800,
        TAP_EXIT1_IR   = 16'h1000,
        TAP_PAUSE_IR   = 16'h2000,
        TAP_EXIT2_IR   = 16'h4000,
        TAP_UPDATE_IR  = 16'h8000
    } sdt_tap_state_type;

    typedef struct packed {
        logic       a_drive;
        logic       b_drive;
        logic [8:0] a_data;
        logic [8:0] b_data;
    } sdt_drive_type;

endpackage

// *** logic/sdt_shift_stage.sv ***
// Capture, shift and update stage shared by instruction and boundary registers
`timescale 1ns/1ps
module sdt_shift_stage #(
    parameter int               WIDTH       = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clear,
    // Strobes
    input  wire logic             capture_en,
    input  wire logic             shift_en,
    input  wire logic             update_en,
    // Data
    input  wire logic             serial_in,
    input  wire logic [WIDTH-1:0] capture_value,
    output logic      [WIDTH-1:0] shift_value,
    output logic      [WIDTH-1:0] update_value
);

    // Highest bit nearest serial input, bit 0 nearest serial output
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_value <= '0;
        end else if (capture_en) begin
            shift_value <= capture_value;
        end else if (shift_en) begin
            shift_value <= {serial_in, shift_value[WIDTH-1:1]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            update_value <= RESET_VALUE;
        end else if (update_en) begin
            update_value <= shift_value;
        end
    end

endmodule

// *** logic/sdt_transceiver.sv ***
// Dual nine-bit transceiver with boundary-scan test logic
`timescale 1ns/1ps
module sdt_transceiver #(
    parameter logic [7:0] IR_CAPTURE_VALUE = sdt_pkg::IR_CAPTURE
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // Group 1 controls
    input  wire logic       group1_direction_select,
    input  wire logic       group1_output_enable_n,
    // Group 2 controls
    input  wire logic       group2_direction_select,
    input  wire logic       group2_output_enable_n,
    // Group 1 pins
    input  wire logic [8:0] group1_a_port_in,
    output logic      [8:0] group1_a_port_out,
    output logic            group1_a_port_oe,
    input  wire logic [8:0] group1_b_port_in,
    output logic      [8:0] group1_b_port_out,
    output logic            group1_b_port_oe,
    // Group 2 pins
    input  wire logic [8:0] group2_a_port_in,
    output logic      [8:0] group2_a_port_out,
    output logic            group2_a_port_oe,
    input  wire logic [8:0] group2_b_port_in,
    output logic      [8:0] group2_b_port_out,
    output logic            group2_b_port_oe,
    // Test access port
    input  wire logic       tap_clock,
    input  wire logic       tap_mode_select,
    input  wire logic       tap_data_in,
    output logic            tap_data_out,
    output logic            tap_data_out_oe
);

    localparam int GW = sdt_pkg::GROUP_WIDTH;
    localparam int BL = sdt_pkg::BSR_LENGTH;

    sdt_pkg::sdt_tap_state_type state_reg;
    sdt_pkg::sdt_tap_state_type state_next;
    sdt_pkg::sdt_drive_type     out_reg [2];
    logic                       tck_reg;
    logic                       bypass_reg;
    logic                       tdo_reg;
    logic                       tdo_oe_reg;
    logic [7:0]                 ir_shift;
    logic [7:0]                 instr;
    logic [BL-1:0]              bsr_shift;
    logic [BL-1:0]              bsr_update;

    wire logic [BL-1:0]         bsr_capture;
    wire sdt_pkg::sdt_drive_type sys_drv [2];
    wire sdt_pkg::sdt_drive_type tst_drv [2];
    wire sdt_pkg::sdt_drive_type fin_drv [2];
    wire logic [1:0]            dir_w;
    wire logic [1:0]            oen_w;
    wire logic [1:0][8:0]       a_in_w;
    wire logic [1:0][8:0]       b_in_w;

    assign dir_w  = {group2_direction_select, group1_direction_select};
    assign oen_w  = {group2_output_enable_n, group1_output_enable_n};
    assign a_in_w = {group2_a_port_in, group1_a_port_in};
    assign b_in_w = {group2_b_port_in, group1_b_port_in};

    // rise and fall of test clock
    wire logic tck_rise = tap_clock & ~tck_reg;
    wire logic tck_fall = ~tap_clock & tck_reg;
    wire logic tms      = tap_mode_select;

    // decode, every unlisted opcode falls to bypass
    wire logic sel_extest = (instr == sdt_pkg::OP_EXTEST);
    wire logic sel_sample = (instr == sdt_pkg::OP_SAMPLE);
    wire logic sel_clamp  = (instr == sdt_pkg::OP_CLAMP);
    wire logic sel_highz  = (instr == sdt_pkg::OP_HIGHZ);
    wire logic bsr_sel    = sel_extest | sel_sample;
    wire logic ctrl_mode  = sel_extest | sel_clamp;

    wire logic in_reset   = (state_reg == sdt_pkg::TAP_RESET);
    // Clear on entry too, so reset never runs a cycle under a stale instruction
    wire logic ir_clear   = in_reset || (tck_rise && state_next == sdt_pkg::TAP_RESET);
    wire logic cap_dr     = tck_rise && state_reg == sdt_pkg::TAP_CAPTURE_DR;
    wire logic sh_dr      = tck_rise && state_reg == sdt_pkg::TAP_SHIFT_DR;
    wire logic up_dr      = tck_fall && state_reg == sdt_pkg::TAP_UPDATE_DR;
    wire logic cap_ir     = tck_rise && state_reg == sdt_pkg::TAP_CAPTURE_IR;
    wire logic sh_ir      = tck_rise && state_reg == sdt_pkg::TAP_SHIFT_IR;
    wire logic up_ir      = tck_fall && state_reg == sdt_pkg::TAP_UPDATE_IR;
    wire logic shifting   = state_reg == sdt_pkg::TAP_SHIFT_DR
                          || state_reg == sdt_pkg::TAP_SHIFT_IR;
    wire logic dr_serial  = bsr_sel ? bsr_shift[0] : bypass_reg;
    wire logic tdo_src    = (state_reg == sdt_pkg::TAP_SHIFT_IR) ? ir_shift[0] : dr_serial;

    genvar g;
    genvar i;
    generate
        for (g = 0; g < sdt_pkg::GROUP_COUNT; g++) begin : grp
            localparam int C = g * sdt_pkg::CTRL_STRIDE;
            // plain non-inverting path chosen by direction
            assign sys_drv[g].a_drive = ~oen_w[g] & ~dir_w[g];
            assign sys_drv[g].b_drive = ~oen_w[g] & dir_w[g];
            assign sys_drv[g].a_data  = b_in_w[g];
            assign sys_drv[g].b_data  = a_in_w[g];
            // control segment: observe direction and enable
            assign bsr_capture[sdt_pkg::BSR_DIR - C] = dir_w[g];
            assign bsr_capture[sdt_pkg::BSR_OEN - C] = oen_w[g];
            // drive enable cells capture and override
            assign bsr_capture[sdt_pkg::BSR_AOE - C] = sys_drv[g].a_drive;
            assign bsr_capture[sdt_pkg::BSR_BOE - C] = sys_drv[g].b_drive;
            assign tst_drv[g].a_drive = bsr_update[sdt_pkg::BSR_AOE - C];
            assign tst_drv[g].b_drive = bsr_update[sdt_pkg::BSR_BOE - C];
            for (i = 0; i < GW; i++) begin : ln
                localparam int L = g * GW + i;
                assign bsr_capture[sdt_pkg::BSR_A_IN - L] = a_in_w[g][i];
                assign bsr_capture[sdt_pkg::BSR_B_IN - L] = b_in_w[g][i];
                assign bsr_capture[sdt_pkg::BSR_B_OUT - L] = sys_drv[g].b_data[i];
                assign bsr_capture[sdt_pkg::BSR_A_OUT - L] = sys_drv[g].a_data[i];
                assign tst_drv[g].b_data[i] = bsr_update[sdt_pkg::BSR_B_OUT - L];
                assign tst_drv[g].a_data[i] = bsr_update[sdt_pkg::BSR_A_OUT - L];
            end
            // select system, cell or floating drive
            assign fin_drv[g] = sel_highz ? '0 : (ctrl_mode ? tst_drv[g] : sys_drv[g]);
        end
    endgenerate

    always_comb begin
        unique case (state_reg)
            sdt_pkg::TAP_RESET:      state_next = tms ? sdt_pkg::TAP_RESET : sdt_pkg::TAP_IDLE;
            sdt_pkg::TAP_IDLE:       state_next = tms ? sdt_pkg::TAP_SEL_DR : sdt_pkg::TAP_IDLE;
            sdt_pkg::TAP_SEL_DR:     state_next = tms ? sdt_pkg::TAP_SEL_IR
                                                      : sdt_pkg::TAP_CAPTURE_DR;
            sdt_pkg::TAP_CAPTURE_DR: state_next = tms ? sdt_pkg::TAP_EXIT1_DR
                                                      : sdt_pkg::TAP_SHIFT_DR;
            sdt_pkg::TAP_SHIFT_DR:   state_next = tms ? sdt_pkg::TAP_EXIT1_DR
                                                      : sdt_pkg::TAP_SHIFT_DR;
            sdt_pkg::TAP_EXIT1_DR:   state_next = tms ? sdt_pkg::TAP_UPDATE_DR
                                                      : sdt_pkg::TAP_PAUSE_DR;
            sdt_pkg::TAP_PAUSE_DR:   state_next = tms ? sdt_pkg::TAP_EXIT2_DR
                                                      : sdt_pkg::TAP_PAUSE_DR;
            sdt_pkg::TAP_EXIT2_DR:   state_next = tms ? sdt_pkg::TAP_UPDATE_DR
                                                      : sdt_pkg::TAP_SHIFT_DR;
            sdt_pkg::TAP_UPDATE_DR:  state_next = tms ? sdt_pkg::TAP_SEL_DR : sdt_pkg::TAP_IDLE;
            sdt_pkg::TAP_SEL_IR:     state_next = tms ? sdt_pkg::TAP_RESET
                                                      : sdt_pkg::TAP_CAPTURE_IR;
            sdt_pkg::TAP_CAPTURE_IR: state_next = tms ? sdt_pkg::TAP_EXIT1_IR
                                                      : sdt_pkg::TAP_SHIFT_IR;
            sdt_pkg::TAP_SHIFT_IR:   state_next = tms ? sdt_pkg::TAP_EXIT1_IR
                                                      : sdt_pkg::TAP_SHIFT_IR;
            sdt_pkg::TAP_EXIT1_IR:   state_next = tms ? sdt_pkg::TAP_UPDATE_IR
                                                      : sdt_pkg::TAP_PAUSE_IR;
            sdt_pkg::TAP_PAUSE_IR:   state_next = tms ? sdt_pkg::TAP_EXIT2_IR
                                                      : sdt_pkg::TAP_PAUSE_IR;
            sdt_pkg::TAP_EXIT2_IR:   state_next = tms ? sdt_pkg::TAP_UPDATE_IR
                                                      : sdt_pkg::TAP_SHIFT_IR;
            sdt_pkg::TAP_UPDATE_IR:  state_next = tms ? sdt_pkg::TAP_SEL_DR : sdt_pkg::TAP_IDLE;
            default:                 state_next = sdt_pkg::TAP_RESET;
        endcase
    end

    // state moves on the rising test clock only
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= sdt_pkg::TAP_RESET;
            tck_reg   <= 1'b0;
        end else begin
            tck_reg <= tap_clock;
            if (tck_rise) begin
                state_reg <= state_next;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bypass_reg <= 1'b0;
        end else if (cap_dr && !bsr_sel) begin
            bypass_reg <= 1'b0;
        end else if (sh_dr && !bsr_sel) begin
            bypass_reg <= tap_data_in;
        end
    end

    // capture value doubles as pseudo identity
    sdt_shift_stage #(
        .WIDTH       (sdt_pkg::IR_WIDTH),
        .RESET_VALUE (sdt_pkg::OP_BYPASS)
    ) u_instr (
        .clk           (ref_clk),
        .rst           (sys_rst),
        .clear         (ir_clear),
        .capture_en    (cap_ir),
        .shift_en      (sh_ir),
        .update_en     (up_ir),
        .serial_in     (tap_data_in),
        .capture_value (IR_CAPTURE_VALUE),
        .shift_value   (ir_shift),
        .update_value  (instr)
    );

    // Preload keeps working under SAMPLE so CLAMP can use it later
    sdt_shift_stage #(
        .WIDTH       (BL),
        .RESET_VALUE (sdt_pkg::BSR_RESET)
    ) u_boundary (
        .clk           (ref_clk),
        .rst           (sys_rst),
        .clear         (1'b0),
        .capture_en    (cap_dr && bsr_sel),
        .shift_en      (sh_dr && bsr_sel),
        .update_en     (up_dr && bsr_sel),
        .serial_in     (tap_data_in),
        .capture_value (bsr_capture),
        .shift_value   (bsr_shift),
        .update_value  (bsr_update)
    );

    // data out changes on the falling test clock
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tdo_reg    <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end else if (tck_fall) begin
            tdo_reg    <= shifting ? tdo_src : tdo_reg;
            tdo_oe_reg <= shifting;
        end
    end

    // pins registered, floating out of reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            out_reg[0] <= '0;
            out_reg[1] <= '0;
        end else begin
            out_reg[0] <= fin_drv[0];
            out_reg[1] <= fin_drv[1];
        end
    end

    assign group1_a_port_out = out_reg[0].a_data;
    assign group1_a_port_oe  = out_reg[0].a_drive;
    assign group1_b_port_out = out_reg[0].b_data;
    assign group1_b_port_oe  = out_reg[0].b_drive;
    assign group2_a_port_out = out_reg[1].a_data;
    assign group2_a_port_oe  = out_reg[1].a_drive;
    assign group2_b_port_out = out_reg[1].b_data;
    assign group2_b_port_oe  = out_reg[1].b_drive;
    assign tap_data_out      = tdo_reg;
    assign tap_data_out_oe   = tdo_oe_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_to_b_a: assert property (
        in_reset && !group1_output_enable_n && group1_direction_select
        |=> group1_b_port_oe && !group1_a_port_oe && group1_b_port_out == $past(group1_a_port_in))
        else $error("group 1 A to B path wrong");
    b_to_a_a: assert property (
        in_reset && !group2_output_enable_n && !group2_direction_select
        |=> group2_a_port_oe && group2_a_port_out == $past(group2_b_port_in))
        else $error("group 2 B to A path wrong");
    float_enable_a: assert property (
        in_reset && group1_output_enable_n |=> !group1_a_port_oe && !group1_b_port_oe)
        else $error("disabled group still drives");
    highz_float_a: assert property (
        sel_highz |=> !group1_a_port_oe && !group1_b_port_oe
                      && !group2_a_port_oe && !group2_b_port_oe)
        else $error("outputs driven under HIGHZ");
    extest_drive_a: assert property (
        sel_extest |=> group2_b_port_oe == $past(bsr_update[sdt_pkg::BSR_BOE - 4])
                       && group2_b_port_out[8] == $past(bsr_update[36])
                       && group2_a_port_out[8] == $past(bsr_update[0]))
        else $error("cell drive not applied");
    bypass_zero_a: assert property (
        cap_dr && !bsr_sel |=> !bypass_reg)
        else $error("bypass did not capture zero");
    ir_capture_a: assert property (
        cap_ir |=> ir_shift == IR_CAPTURE_VALUE && ir_shift[1:0] == 2'b01)
        else $error("instruction capture wrong");
    observe_dir_a: assert property (
        cap_dr && bsr_sel |=> bsr_shift[79] == $past(group1_direction_select)
                             && bsr_shift[71] == $past(group1_a_port_in[0]))
        else $error("boundary capture misplaced");
    tdo_fall_a: assert property (
        $changed(tdo_reg) |-> $past(tck_fall))
        else $error("data out moved off falling edge");
    update_ir_a: assert property (
        up_ir |=> instr == $past(ir_shift))
        else $error("instruction not updated");
    tlr_exit_a: assert property (
        tck_rise && tms && state_reg == sdt_pkg::TAP_SEL_IR |=> in_reset ##0 instr == 8'hff)
        else $error("reset state not reached");
    tdo_enable_a: assert property (
        tck_fall |=> tap_data_out_oe == $past(shifting))
        else $error("data out enable wrong");

    extest_c: cover property (sel_extest && tck_fall);
    sample_c: cover property (sel_sample && cap_dr);
    clamp_c:  cover property (sel_clamp ##1 group1_b_port_oe);
    highz_c:  cover property (sel_highz && !group1_output_enable_n);

endmodule

// *** tb/sdt_tap_driver.sv ***
// Behavioural boundary-scan controller driving the test access port
`timescale 1ns/1ps
module sdt_tap_driver (
    // Clock
    input  wire logic ref_clk,
    // Test access port
    output logic      tap_clock,
    output logic      tap_mode_select,
    output logic      tap_data_in,
    input  wire logic tap_data_out
);
    // The test clock stays high four system clocks and low five between pulses, above the minimum of two
    localparam int HALF = 4;

    initial begin
        tap_clock       = 1'b0;
        tap_mode_select = 1'b1;
        tap_data_in     = 1'b0;
    end

    // change while low, sample before rise
    task automatic pulse(input logic tms, input logic tdi, output logic tdo);
        @(posedge ref_clk);
        #1;
        tap_mode_select = tms;
        tap_data_in     = tdi;
        repeat (HALF) @(posedge ref_clk);
        #1;
        tdo       = tap_data_out;
        tap_clock = 1'b1;
        repeat (HALF) @(posedge ref_clk);
        #1;
        tap_clock = 1'b0;
    endtask

    task automatic reset_tap();
        logic b;
        repeat (5) pulse(1'b1, 1'b0, b);
        pulse(1'b0, 1'b0, b);
    endtask

    // instruction capture read back as identity
    task automatic scan(input logic is_ir, input int n, input logic [79:0] din,
                        output logic [79:0] dout);
        logic b;
        dout = '0;
        pulse(1'b1, 1'b0, b);
        if (is_ir)
            pulse(1'b1, 1'b0, b);
        pulse(1'b0, 1'b0, b);
        pulse(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], b);
            dout[i] = b;
        end
        pulse(1'b1, 1'b0, b);
        pulse(1'b0, 1'b0, b);
    endtask
endmodule

// *** tb/sdt_transceiver_bench.sv ***
// Self-checking bench for the scannable dual byte transceiver
`timescale 1ns/1ps
module sdt_transceiver_bench;
    localparam logic [7:0] CAPTURE = 8'h95; // Arbitrary value, low bits 01
    logic       ref_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [1:0] dir     = 2'b00;
    logic [1:0] oen     = 2'b11;
    logic [8:0] ain [2] = '{9'h000, 9'h000};
    logic [8:0] bin [2] = '{9'h000, 9'h000};
    logic [31:0] seed   = 32'h0afa;
    logic [79:0] pat;
    logic [79:0] dout;
    int          mismatches = 0;
    int          n_checks   = 0;
    wire         tck, tms, tdi, tdo, tdo_oe;
    wire sdt_pkg::sdt_drive_type got [2];

    always #10 ref_clk = ~ref_clk;

    sdt_transceiver #(.IR_CAPTURE_VALUE(CAPTURE)) uut (
        .ref_clk(ref_clk), .sys_rst(sys_rst),
        .group1_direction_select(dir[0]), .group1_output_enable_n(oen[0]),
        .group2_direction_select(dir[1]), .group2_output_enable_n(oen[1]),
        .group1_a_port_in(ain[0]), .group1_a_port_out(got[0].a_data),
        .group1_a_port_oe(got[0].a_drive), .group1_b_port_in(bin[0]),
        .group1_b_port_out(got[0].b_data), .group1_b_port_oe(got[0].b_drive),
        .group2_a_port_in(ain[1]), .group2_a_port_out(got[1].a_data),
        .group2_a_port_oe(got[1].a_drive), .group2_b_port_in(bin[1]),
        .group2_b_port_out(got[1].b_data), .group2_b_port_oe(got[1].b_drive),
        .tap_clock(tck), .tap_mode_select(tms), .tap_data_in(tdi),
        .tap_data_out(tdo), .tap_data_out_oe(tdo_oe));

    sdt_tap_driver tap (.ref_clk(ref_clk), .tap_clock(tck), .tap_mode_select(tms),
                        .tap_data_in(tdi), .tap_data_out(tdo));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Undriven sides carry no meaningful data
    function automatic sdt_pkg::sdt_drive_type mask(input sdt_pkg::sdt_drive_type d);
        mask = d;
        if (!d.a_drive) mask.a_data = '0;
        if (!d.b_drive) mask.b_data = '0;
    endfunction

    function automatic sdt_pkg::sdt_drive_type sys_exp(input int g);
        return {~oen[g] & ~dir[g], ~oen[g] & dir[g], bin[g], ain[g]};
    endfunction

    function automatic sdt_pkg::sdt_drive_type cell_exp(input logic [79:0] p, input int g);
        cell_exp.a_drive = p[77 - 4 * g];
        cell_exp.b_drive = p[76 - 4 * g];
        for (int i = 0; i < 9; i++) begin
            cell_exp.a_data[i] = p[17 - 9 * g - i];
            cell_exp.b_data[i] = p[53 - 9 * g - i];
        end
    endfunction

    function automatic logic [79:0] sample_exp();
        logic [79:0] v;
        v = '0;
        for (int g = 0; g < 2; g++) begin
            v[79 - 4 * g -: 4] = {dir[g], oen[g], ~oen[g] & ~dir[g], ~oen[g] & dir[g]};
            for (int i = 0; i < 9; i++) begin
                v[71 - 9 * g - i] = ain[g][i];
                v[53 - 9 * g - i] = ain[g][i];
                v[35 - 9 * g - i] = bin[g][i];
                v[17 - 9 * g - i] = bin[g][i];
            end
        end
        return v;
    endfunction

    task automatic fail(input string m);
        mismatches++;
        $display("[ERR] %0t %s", $time, m);
    endtask

    task automatic cmp_drv(input sdt_pkg::sdt_drive_type e, input sdt_pkg::sdt_drive_type g);
        n_checks++;
        if (mask(e) !== mask(g)) fail($sformatf("pins exp %h got %h", e, g));
    endtask

    task automatic cmp_bits(input logic [79:0] e, input logic [79:0] g);
        n_checks++;
        if (e !== g) fail($sformatf("scan exp %h got %h", e, g));
    endtask

    task automatic rnd_pins();
        repeat (16) seed = lfsr(seed);
        {dir, oen, ain[1], ain[0]} = seed[21:0];
        repeat (16) seed = lfsr(seed);
        {bin[1], bin[0]} = seed[17:0];
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk_sys();
        for (int g = 0; g < 2; g++) cmp_drv(sys_exp(g), got[g]);
    endtask

    task automatic chk_cells(input logic [79:0] p);
        for (int g = 0; g < 2; g++) cmp_drv(cell_exp(p, g), got[g]);
    endtask

    task automatic bypass_chk();
        tap.scan(1'b0, 2, 80'h3, dout);
        cmp_bits(80'h2, dout);
        cmp_bits(80'h0, {79'h0, tdo_oe});
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        for (int k = 0; k < 150; k++) begin
            rnd_pins();
            if (k < 16) {dir, oen} = k[3:0];
            @(posedge ref_clk);
            #1;
            chk_sys();
        end
        tap.reset_tap();
        tap.scan(1'b1, 8, {72'h0, sdt_pkg::OP_SAMPLE}, dout);
        cmp_bits({72'h0, CAPTURE}, dout);
        rnd_pins();
        chk_sys();
        repeat (3) seed = lfsr(seed);
        pat = {seed[15:0], seed, seed};
        tap.scan(1'b0, 80, pat, dout);
        cmp_bits(sample_exp(), dout);
        chk_sys();
        tap.scan(1'b1, 8, {72'h0, sdt_pkg::OP_EXTEST}, dout);
        rnd_pins();
        chk_cells(pat);
        pat = ~pat;
        tap.scan(1'b0, 80, pat, dout);
        cmp_bits(sample_exp(), dout);
        rnd_pins();
        chk_cells(pat);
        tap.scan(1'b1, 8, {72'h0, sdt_pkg::OP_CLAMP}, dout);
        rnd_pins();
        chk_cells(pat);
        bypass_chk();
        tap.scan(1'b1, 8, {72'h0, sdt_pkg::OP_HIGHZ}, dout);
        rnd_pins();
        chk_cells(80'h0);
        bypass_chk();
        for (int k = 0; k < 4; k++) begin
            tap.scan(1'b1, 8, {72'h0, 8'h5a ^ k[7:0] ^ {k[0], 7'h00}}, dout);
            rnd_pins();
            chk_sys();
            bypass_chk();
        end
        tap.scan(1'b1, 8, {72'h0, sdt_pkg::OP_EXTEST}, dout);
        tap.reset_tap();
        rnd_pins();
        chk_sys();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        fail("watchdog expired");
        summarize();
    end
endmodule
